// ==== hdl/run_mode_trigger_control.sv ====
// run-mode controller: AXI4-Lite registers, input qualification, playback control
// assumes inputs synchronous to aclk; engine pulses cycle_done at each waveform end
//
// Contract
// - event slope readback returns rising, falling or both as stored
// - TTL preset loads event threshold with 1.6 V
// - enable request starts output only in continuous armed mode
// - abort stops playback at once and drives selected idle output
// - continuous self mode runs as soon as a waveform is selected
// - continuous armed mode holds off until an enable arrives
// - enable mode and source matter only in continuous mode
// - run mode defaults continuous; zero selects triggered mode
// - bus enable source: only remote enable starts, event input ignored
// - event enable source: first event starts, remote enable ignored
// - trigger enable source: first trigger starts, remote enable ignored
// - gated mode outputs only while the gate is true
// - remote trigger acts only in triggered mode with bus source
// - burst count 1 to 16,777,216, default 1, triggered mode only
// - after each trigger output exactly the count then idle
// - burst starts from push-button, remote trigger or trigger input
// - event and trigger settings stay separate per input
// - event edges qualified by stored slope
// - abort also acts in triggered mode; in gated mode it drops output for one cycle only, then the gate resumes it
`include "run_mode_defines.svh"
`default_nettype none
module run_mode_trigger_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_in,
  input wire logic trigger_in,
  input wire logic manual_button,
  input wire logic cycle_done,
  output run_mode_pkg::play_ctl_s play_ctl,
  output logic [15:0] event_level_mv
);
  import run_mode_pkg::*;
  // ****************************************
  // registers
  // ****************************************
  logic cont_q, gate_q, armed_q, tsrc_bus_q;
  ensrc_e src_q;
  idle_e idle_q;
  slope_e evt_slope_q, trg_slope_q;
  logic [15:0] evt_level_q;
  logic [24:0] burst_q;
  run_state_e state_q;
  logic [24:0] cnt_q;
  logic running_q;

  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;
  logic wr_fire;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready;
      s_axi_wready <= !w_have_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= `OFS_TRIGCFG && awaddr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // write decode
  logic [31:0] ctrl_rd, evt_rd, trigcfg_rd, stat_rd;
  logic wr_ctrl, wr_evt, wr_burst, wr_cmd, wr_trig;
  assign wr_ctrl = wr_fire && awaddr_q == `OFS_CTRL;
  assign wr_evt = wr_fire && awaddr_q == `OFS_EVT;
  assign wr_burst = wr_fire && awaddr_q == `OFS_BURST;
  assign wr_cmd = wr_fire && awaddr_q == `OFS_CMD && wstrb_q[0];
  assign wr_trig = wr_fire && awaddr_q == `OFS_TRIGCFG;
  logic [31:0] ctrl_new, evt_new, burst_new;
  assign ctrl_new = merge(ctrl_rd, wdata_q, wstrb_q);
  assign evt_new = merge(evt_rd, wdata_q, wstrb_q);
  assign burst_new = merge({7'h00, burst_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cont_q <= 1'b1;
      gate_q <= 1'b0;
      armed_q <= 1'b0;
      src_q <= SRC_BUS;
      tsrc_bus_q <= 1'b0;
      idle_q <= IDLE_DC;
    end else if (wr_ctrl) begin
      cont_q <= ctrl_new[`CTRL_CONT_BIT];
      gate_q <= ctrl_new[`CTRL_GATE_BIT];
      armed_q <= ctrl_new[`CTRL_ARMED_BIT];
      src_q <= (ctrl_new[`CTRL_SRC_LSB +: 2] == 2'd3) ? SRC_BUS : ensrc_e'(ctrl_new[`CTRL_SRC_LSB +: 2]);
      tsrc_bus_q <= ctrl_new[`CTRL_TSRC_BIT];
      idle_q <= (ctrl_new[`CTRL_IDLE_LSB +: 2] == 2'd3) ? IDLE_DC : idle_e'(ctrl_new[`CTRL_IDLE_LSB +: 2]);
    end
  end
  // event input settings only; trigger slope lives apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_slope_q <= SLOPE_RISE;
      evt_level_q <= `LEVEL_RST_MV;
    end else if (wr_evt) begin
      evt_slope_q <= (evt_new[1:0] == 2'd3) ? SLOPE_BOTH : slope_e'(evt_new[1:0]);
      if (evt_new[`EVT_TTL_BIT]) begin
        evt_level_q <= `LEVEL_TTL_MV;
      end else if (evt_new[`EVT_ECL_BIT]) begin
        evt_level_q <= `LEVEL_ECL_MV;
      end else begin
        evt_level_q <= evt_new[`EVT_LEVEL_LSB +: 16];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trg_slope_q <= SLOPE_RISE;
    end else if (wr_trig) begin
      trg_slope_q <= (wdata_q[1:0] == 2'd3) ? SLOPE_BOTH : slope_e'(wdata_q[1:0]);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_q <= `BURST_RST;
    end else if (wr_burst) begin
      if (burst_new[24:0] == 25'd0) begin
        burst_q <= 25'd1;
      end else if (burst_new[24:0] > `BURST_MAX) begin
        burst_q <= `BURST_MAX;
      end else begin
        burst_q <= burst_new[24:0];
      end
    end
  end
  assign ctrl_rd = {22'h0, idle_q, 1'b0, tsrc_bus_q, src_q, 1'b0, armed_q, gate_q, cont_q};
  assign evt_rd = {evt_level_q, 14'h0, evt_slope_q};
  assign trigcfg_rd = {30'h0, trg_slope_q};
  assign stat_rd = {28'h0, running_q, state_q};
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `OFS_CTRL: s_axi_rdata <= ctrl_rd;
          `OFS_EVT: s_axi_rdata <= evt_rd;
          `OFS_BURST: s_axi_rdata <= {7'h00, burst_q};
          `OFS_CMD: s_axi_rdata <= 32'h0000_0000;
          `OFS_STAT: s_axi_rdata <= stat_rd;
          `OFS_TRIGCFG: s_axi_rdata <= trigcfg_rd;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // input qualification
  // ****************************************
  logic [2:0] evt_sync_q, trg_sync_q, btn_sync_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_sync_q <= 3'b000;
      trg_sync_q <= 3'b000;
      btn_sync_q <= 3'b000;
    end else begin
      evt_sync_q <= {evt_sync_q[1:0], event_in};
      trg_sync_q <= {trg_sync_q[1:0], trigger_in};
      btn_sync_q <= {btn_sync_q[1:0], manual_button};
    end
  end

  function automatic logic edge_hit(input logic [1:0] s, input slope_e sl);
    logic r;
    r = 1'b0;
    case (sl)
      SLOPE_RISE: r = !s[1] && s[0];
      SLOPE_FALL: r = s[1] && !s[0];
      SLOPE_BOTH: r = s[1] ^ s[0];
      default: r = 1'b0;
    endcase
    return r;
  endfunction
  logic evt_pulse, trg_pulse, btn_pulse, gate_level;
  assign evt_pulse = edge_hit(evt_sync_q[2:1], evt_slope_q);
  assign trg_pulse = edge_hit(trg_sync_q[2:1], trg_slope_q);
  assign btn_pulse = btn_sync_q[1] && !btn_sync_q[2];
  assign gate_level = (trg_slope_q == SLOPE_FALL) ? !trg_sync_q[1] : trg_sync_q[1];

  // ****************************************
  // run-mode state machine
  // ****************************************
  logic cmd_enable, cmd_abort, cmd_trig, cmd_select;
  assign cmd_enable = wr_cmd && wdata_q[`CMD_ENABLE_BIT];
  assign cmd_abort = wr_cmd && wdata_q[`CMD_ABORT_BIT];
  assign cmd_trig = wr_cmd && wdata_q[`CMD_TRIG_BIT];
  assign cmd_select = wr_cmd && wdata_q[`CMD_SELECT_BIT];
  logic cont_start, burst_start, trig_mode;
  assign trig_mode = !cont_q && !gate_q;
  always_comb begin
    cont_start = 1'b0;
    if (cont_q && !gate_q) begin
      if (!armed_q) begin
        cont_start = cmd_select;
      end else begin
        case (src_q)
          SRC_BUS: cont_start = cmd_enable;
          SRC_EVENT: cont_start = evt_pulse;
          SRC_TRIG: cont_start = trg_pulse;
          default: cont_start = 1'b0;
        endcase
      end
    end
  end
  assign burst_start = trig_mode && ((cmd_trig && tsrc_bus_q) || btn_pulse || (trg_pulse && !tsrc_bus_q));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 25'd0;
    end else if (cmd_abort) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cont_start) begin
            state_q <= ST_RUN;
          end else if (burst_start) begin
            state_q <= ST_BURST;
            cnt_q <= burst_q;
          end
        end
        ST_RUN: begin
          if (!(cont_q && !gate_q)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_BURST: begin
          if (!trig_mode) begin
            state_q <= ST_IDLE;
          end else if (cycle_done) begin
            cnt_q <= cnt_q - 25'd1;
            if (cnt_q == 25'd1) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // self mode on reset is dormant until a waveform select, which starts it
  logic run_d;
  assign run_d = (state_q != ST_IDLE) || (gate_q && gate_level);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_q <= 1'b0;
      play_ctl <= '{run: 1'b0, idle_out: 1'b1, idle_kind: IDLE_DC};
      event_level_mv <= `LEVEL_RST_MV;
    end else begin
      running_q <= run_d && !cmd_abort;
      play_ctl.run <= run_d && !cmd_abort;
      play_ctl.idle_out <= !(run_d && !cmd_abort);
      play_ctl.idle_kind <= idle_q;
      event_level_mv <= evt_level_q;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/run_mode_defines.svh ====
// run-mode controller constants: register offsets, field positions, resets
// assumes inclusion by bare name from design and bench files
`ifndef RUN_MODE_DEFINES_SVH
`define RUN_MODE_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_EVT 8'h04
`define OFS_BURST 8'h08
`define OFS_CMD 8'h0C
`define OFS_STAT 8'h10
`define OFS_TRIGCFG 8'h14
// control register fields
`define CTRL_CONT_BIT 0
`define CTRL_GATE_BIT 1
`define CTRL_ARMED_BIT 2
`define CTRL_SRC_LSB 4
`define CTRL_TSRC_BIT 6
`define CTRL_IDLE_LSB 8
// event config fields: slope at [1:0], level (mV, signed 16) at [31:16]
`define EVT_SLOPE_LSB 0
`define EVT_TTL_BIT 2
`define EVT_ECL_BIT 3
`define EVT_LEVEL_LSB 16
// command register bits (write one to act)
`define CMD_ENABLE_BIT 0
`define CMD_ABORT_BIT 1
`define CMD_TRIG_BIT 2
`define CMD_SELECT_BIT 3
// reset values and limits
`define LEVEL_TTL_MV 16'h0640
`define LEVEL_ECL_MV 16'hFAEC
`define LEVEL_RST_MV 16'h0640
`define BURST_RST 25'h000_0001
`define BURST_MAX 25'h100_0000
`endif

// ==== hdl/run_mode_pkg.sv ====
// run-mode controller types
// assumes nothing outside itself
`default_nettype none
package run_mode_pkg;
  typedef enum logic [1:0] {SLOPE_RISE = 2'd0, SLOPE_FALL = 2'd1, SLOPE_BOTH = 2'd2} slope_e;
  typedef enum logic [1:0] {SRC_BUS = 2'd0, SRC_EVENT = 2'd1, SRC_TRIG = 2'd2} ensrc_e;
  typedef enum logic [1:0] {IDLE_DC = 2'd0, IDLE_FIRST_WAVE = 2'd1, IDLE_FIRST_SEQ = 2'd2} idle_e;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_BURST = 3'b100} run_state_e;
  typedef struct packed {
    logic run;
    logic idle_out;
    idle_e idle_kind;
  } play_ctl_s;
endpackage
`default_nettype wire

// ==== sim/playback_engine_model.sv ====
// playback engine stand-in: ends one waveform cycle every PERIOD clocks of run
// assumes play_ctl from the controller on the same clock
`default_nettype none
module playback_engine_model #(
  parameter int PERIOD = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire run_mode_pkg::play_ctl_s play_ctl,
  output logic cycle_done
);
  timeunit 1ns;
  timeprecision 1ns;
  import run_mode_pkg::*;
  int cnt_q;
  // ****
  // cycle counter, cleared whenever playback stops
  // ****
  always_ff @(posedge aclk) begin
    if (!aresetn || !play_ctl.run) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    end
  end
  always_ff @(posedge aclk) begin
    cycle_done <= aresetn && play_ctl.run && cnt_q == PERIOD - 1;
  end
endmodule
`default_nettype wire

// ==== sim/run_mode_trigger_control_props.sv ====
// checker: assertions on the run-mode controller ports
// assumes bind into run_mode_trigger_control, one clock aclk
`include "run_mode_defines.svh"
`default_nettype none
module run_mode_trigger_control_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_in,
  input wire logic trigger_in,
  input wire logic manual_button,
  input wire logic cycle_done,
  input wire run_mode_pkg::play_ctl_s play_ctl,
  input wire logic [15:0] event_level_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  import run_mode_pkg::*;
  logic wr_hs;
  logic [2:0] in_q;
  logic [3:0] cause_q;
  logic [3:0] evw_q;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // ****
  // windows after stimulus that may start or stop playback, and after event writes that may change the level
  // ****
  always_ff @(posedge aclk) begin
    in_q <= {event_in, trigger_in, manual_button};
    if (!aresetn) begin
      cause_q <= 4'h0;
    end else if (wr_hs || cycle_done || in_q != {event_in, trigger_in, manual_button}) begin
      cause_q <= 4'hf;
    end else if (cause_q != 4'h0) begin
      cause_q <= cause_q - 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evw_q <= 4'h0;
    end else if (wr_hs && s_axi_awaddr == `OFS_EVT) begin
      evw_q <= 4'h4;
    end else if (evw_q != 4'h0) begin
      evw_q <= evw_q - 4'h1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_idle_flag: assert property (play_ctl.idle_out == !play_ctl.run)
    else $error("idle flag not inverse of run");
  chk_abort_stop: assert property (wr_hs && s_axi_awaddr == `OFS_CMD && s_axi_wdata[1] |-> ##[2:3] !play_ctl.run)
    else $error("abort did not stop playback");
  chk_ttl_level: assert property (wr_hs && s_axi_awaddr == `OFS_EVT && s_axi_wdata[2]
    |-> ##[1:3] event_level_mv == `LEVEL_TTL_MV)
    else $error("ttl preset level wrong");
  chk_level_source: assert property ($changed(event_level_mv) |-> evw_q != 4'h0)
    else $error("event level changed without event write");
  chk_run_cause: assert property ($rose(play_ctl.run) |-> cause_q != 4'h0)
    else $error("playback started without a cause");
  chk_run_drop: assert property ($fell(play_ctl.run) |-> cause_q != 4'h0)
    else $error("playback stopped without a cause");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  cov_abort: cover property (wr_hs && s_axi_awaddr == `OFS_CMD && s_axi_wdata[1] && play_ctl.run);
  cov_burst_end: cover property (cycle_done ##[1:3] $fell(play_ctl.run));
  cov_ttl: cover property (wr_hs && s_axi_awaddr == `OFS_EVT && s_axi_wdata[2]);
endmodule
bind run_mode_trigger_control run_mode_trigger_control_props i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .event_in(event_in), .trigger_in(trigger_in), .manual_button(manual_button), .cycle_done(cycle_done),
  .play_ctl(play_ctl), .event_level_mv(event_level_mv));
`default_nettype wire

// ==== sim/run_mode_trigger_control_test.sv ====
// bench: slopes and levels, then table of run-mode cases, then event slope, gate, burst and abort
// assumes design, engine model and checker compiled before it
`include "run_mode_defines.svh"
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", nm, e, g); end end
module run_mode_trigger_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import run_mode_pkg::*;
  typedef struct packed {logic [9:0] ctrl; logic [2:0] act; logic run;} row_s;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic event_in = 1'h0, trigger_in = 1'h0, manual_button = 1'h0, awready, wready, bvalid, arready, rvalid, cycle_done;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, d, rdata;
  logic [1:0] r, bresp, rresp;
  logic [15:0] lvl;
  play_ctl_s play_ctl;
  int n_fail = 0, comparisons = 0, k;
  // ****
  // control word, action (0 enable, 1 select, 2 event, 3 trigger, 4 bus trigger, 5 button), run
  // ****
  row_s rows [14] = '{{10'h001, 3'h1, 1'h1}, {10'h005, 3'h1, 1'h0}, {10'h005, 3'h0, 1'h1}, {10'h005, 3'h2, 1'h0},
    {10'h015, 3'h0, 1'h0}, {10'h015, 3'h2, 1'h1}, {10'h025, 3'h0, 1'h0}, {10'h025, 3'h3, 1'h1},
    {10'h040, 3'h0, 1'h0}, {10'h040, 3'h4, 1'h1}, {10'h000, 3'h4, 1'h0}, {10'h000, 3'h3, 1'h1},
    {10'h000, 3'h5, 1'h1}, {10'h010, 3'h2, 1'h0}};
  always #10 aclk = ~aclk;
  run_mode_trigger_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_in(event_in), .trigger_in(trigger_in),
    .manual_button(manual_button), .cycle_done(cycle_done), .play_ctl(play_ctl), .event_level_mv(lvl));
  playback_engine_model i_eng (.aclk(aclk), .aresetn(aresetn), .play_ctl(play_ctl), .cycle_done(cycle_done));
  task wrap_up;
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h1;
    for (n = 0; n < 50 && b; n++) begin
      @(posedge aclk);
      if (!aw && !w && bvalid === 1'h1) begin
        b = 1'h0;
        r = bresp;
        bready <= 1'h0;
      end
      if (aw && awready === 1'h1) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready === 1'h1) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
    end
    if (b) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task axr(input logic [7:0] a);
    logic ar, b;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    ar = 1'h1;
    b = 1'h1;
    for (n = 0; n < 50 && b; n++) begin
      @(posedge aclk);
      if (!ar && rvalid === 1'h1) begin
        b = 1'h0;
        d = rdata;
        r = rresp;
        rready <= 1'h0;
      end
      if (ar && arready === 1'h1) begin
        ar = 1'h0;
        arvalid <= 1'h0;
      end
    end
    if (b) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task act(input logic [2:0] a);
    case (a)
      3'h0: axw(`OFS_CMD, 32'h0000_0001);
      3'h1: axw(`OFS_CMD, 32'h0000_0008);
      3'h4: axw(`OFS_CMD, 32'h0000_0004);
      default: begin
        @(posedge aclk);
        event_in <= (a == 3'h2);
        trigger_in <= (a == 3'h3);
        manual_button <= (a == 3'h5);
        wt(3);
        event_in <= 1'h0;
        trigger_in <= 1'h0;
        manual_button <= 1'h0;
        wt(3);
      end
    endcase
  endtask
  task setup(input logic [9:0] c);
    axw(`OFS_CMD, 32'h0000_0002);
    axw(`OFS_CTRL, {22'h00_0000, c});
  endtask
  initial begin
    wt(10);
    aresetn <= 1'h1;
    axr(`OFS_CTRL);
    `CHK("cont", 1'h1, d[0])
    axr(`OFS_BURST);
    `CHK("burst", `BURST_RST, d[24:0])
    `CHK("level", `LEVEL_RST_MV, lvl)
    axr(8'h40);
    `CHK("resp", 2'h2, r)
    axw(8'h40, 32'h0000_0000);
    `CHK("bresp", 2'h2, r)
    for (k = 0; k < 3; k++) begin
      axw(`OFS_EVT, 32'(k));
      axr(`OFS_EVT);
      `CHK("slope", 2'(k), d[1:0])
    end
    `CHK("level", 16'h0000, lvl)
    axw(`OFS_EVT, 32'h0000_0008);
    wt(1);
    `CHK("level", `LEVEL_ECL_MV, lvl)
    axw(`OFS_EVT, 32'h0000_0004);
    wt(1);
    `CHK("level", `LEVEL_TTL_MV, lvl)
    axw(`OFS_TRIGCFG, 32'h0000_0001);
    axw(`OFS_TRIGCFG, 32'h0000_0000);
    `CHK("bresp", 2'h0, r)
    `CHK("level", `LEVEL_TTL_MV, lvl)
    foreach (rows[i]) begin
      setup(rows[i].ctrl);
      act(rows[i].act);
      wt(8);
      `CHK("run", rows[i].run, play_ctl.run)
    end
    setup(10'h015);
    axw(`OFS_EVT, 32'h0640_0001);
    event_in <= 1'h1;
    wt(8);
    `CHK("run", 1'h0, play_ctl.run)
    event_in <= 1'h0;
    wt(8);
    `CHK("run", 1'h1, play_ctl.run)
    setup(10'h002);
    trigger_in <= 1'h1;
    wt(8);
    `CHK("run", 1'h1, play_ctl.run)
    trigger_in <= 1'h0;
    wt(8);
    `CHK("run", 1'h0, play_ctl.run)
    axw(`OFS_TRIGCFG, 32'h0000_0001);
    wt(8);
    `CHK("run", 1'h1, play_ctl.run)
    axw(`OFS_TRIGCFG, 32'h0000_0000);
    setup(10'h000);
    axw(`OFS_BURST, 32'h0000_0003);
    act(3'h3);
    k = 0;
    repeat (300) begin
      @(posedge aclk);
      if (cycle_done === 1'h1) k++;
    end
    `CHK("count", 3, k)
    `CHK("run", 1'h0, play_ctl.run)
    axw(`OFS_BURST, 32'h0000_0000);
    axr(`OFS_BURST);
    `CHK("burst", 25'h000_0001, d[24:0])
    axw(`OFS_BURST, 32'h01FF_FFFF);
    axr(`OFS_BURST);
    `CHK("burst", `BURST_MAX, d[24:0])
    setup(10'h200);
    act(3'h3);
    `CHK("run", 1'h1, play_ctl.run)
    axw(`OFS_CMD, 32'h0000_0002);
    `CHK("run", 1'h0, play_ctl.run)
    `CHK("idle", IDLE_FIRST_SEQ, play_ctl.idle_kind)
    wrap_up();
  end
endmodule
`default_nettype wire
